// ---- logic/pbr_pkg.sv ----
// Constants, field layout and carrier types of the PHY self-test, LED and misc register group
//
// Overview of operation
// - Status bit 11 shows 1 while the PRBS checker is locked.
// - Status bit 10 latches high on PRBS sync loss.
// - Status bit 9 shows 1 while the packet generator is busy.
// - Status bit 8 shows 1 in normal power, 0 when down or asleep.
// - Sixteen-bit count of bytes taken in by the PRBS checker.
// - Visible byte count freezes on an error count write with bit 0 or 1.
// - Single count mode stops the byte counter at all ones.
// - Eight-bit error byte count in low bits, upper byte reads zero.
// - Single count mode halts the error counter at its maximum.
// - Bit 0 write latches both counters; bit 1 latches then clears them.
// - Packet length register, read/write, resets to 1500 bytes.
// - Inter-packet gap register, read/write, resets to 125 bytes.
// - LED bit 15 enables the LED outputs, reset value one.
// - Two-bit pulse stretch: 50, 100, 200 or 500 ms, reset 200 ms.
// - LED bit 12 forces the interrupt output; zero keeps normal signalling.
// - Two-bit blink rate: 20, 10, 5 or 2 Hz, reset 5 Hz.
// - Two-bit LED mode: 01 first, 00 second, 10 third, strap loaded.
// - Per-LED polarity bits, strap loaded; 0 active low, 1 active high.
// - Writing bit 15 of soft reset register resets all but the read data path and strap inputs, then self clears.
// - Count nibble times of error symbols between idles in an 8-bit field.
// - Reading the false carrier counter register clears it.
// - Single mode stops both counters at a maximum; continuous pulses and wraps.
// - Generator runs only while its enable bit is one.
package pbr_pkg;

  // ==========================================================
  // Register access and offsets
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] ADDR_SELFTEST_STATUS = 8'h17;
  localparam logic [7:0] ADDR_LED_DIRECT_CONTROL = 8'h18;
  localparam logic [7:0] ADDR_SOFT_RESET_CONTROL = 8'h1F;
  localparam logic [7:0] ADDR_FALSE_CARRIER_COUNTER = 8'h42;
  localparam logic [7:0] ADDR_SELFTEST_BYTE_COUNT = 8'h71;
  localparam logic [7:0] ADDR_SELFTEST_ERROR_COUNT = 8'h72;
  localparam logic [7:0] ADDR_SELFTEST_PACKET_LENGTH = 8'h7B;
  localparam logic [7:0] ADDR_SELFTEST_PACKET_GAP = 8'h7C;

  // ==========================================================
  // Field positions and reset values
  localparam int STAT_LOCKED_BIT = 11;
  localparam int STAT_SYNC_LOSS_BIT = 10;
  localparam int STAT_GEN_BUSY_BIT = 9;
  localparam int STAT_POWER_BIT = 8;
  localparam int LED_EN_BIT = 15;
  localparam int LED_PW_LSB = 13;
  localparam int LED_FORCE_INT_BIT = 12;
  localparam int LED_BLINK_LSB = 8;
  localparam int LED_MODE_LSB = 5;
  localparam int LED_POL_LSB = 0;
  localparam int SOFT_RESET_BIT = 15;
  localparam int LOCK_BIT = 0;
  localparam int LOCK_CLR_BIT = 1;
  localparam logic LED_EN_RST = 1'b1;
  localparam logic [1:0] LED_PW_RST = 2'h2;
  localparam logic LED_FORCE_RST = 1'b0;
  localparam logic [1:0] LED_BLINK_RST = 2'h2;
  localparam logic [15:0] PKT_LEN_RST = 16'h05DC;
  localparam logic [15:0] PKT_GAP_RST = 16'h007D;
  localparam int BYTE_CNT_W = 16;
  localparam int ERR_CNT_W = 8;
  localparam int FC_CNT_W = 8;
  localparam logic [1:0] LED_MODE1 = 2'h1;
  localparam logic [1:0] LED_MODE2 = 2'h0;
  localparam logic [1:0] LED_MODE3 = 2'h2;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
  localparam int MS_W = 10;
  localparam logic [9:0] PERIOD_50_MS = 10'h032;
  localparam logic [9:0] PERIOD_100_MS = 10'h064;
  localparam logic [9:0] PERIOD_200_MS = 10'h0C8;
  localparam logic [9:0] PERIOD_500_MS = 10'h1F4;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic locked;
    logic sync_loss;
    logic byte_valid;
    logic byte_err;
  } pbr_chk_t;

  typedef struct packed {
    logic act;
    logic speed;
    logic link;
  } pbr_led_in_t;

  typedef struct packed {
    logic en;
    logic [1:0] pulse_width;
    logic [1:0] blink_rate;
    logic [1:0] mode;
    logic [2:0] pol;
  } pbr_led_cfg_t;

  // Two-bit time code to milliseconds, shared by pulse width and blink rate
  function automatic logic [9:0] pbr_code_ms(input logic [1:0] code);
    case (code)
      2'h0: pbr_code_ms = PERIOD_50_MS;
      2'h1: pbr_code_ms = PERIOD_100_MS;
      2'h2: pbr_code_ms = PERIOD_200_MS;
      default: pbr_code_ms = PERIOD_500_MS;
    endcase
  endfunction : pbr_code_ms

endpackage : pbr_pkg

// ---- logic/pbr_sat_counter.sv ----
// Event counter that either stops at all ones or wraps with a pulse
module pbr_sat_counter
  import pbr_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic inc,
  input wire logic hold,
  // Count
  output logic [W-1:0] count,
  output logic at_max,
  output logic wrap_pulse
);

  logic [W-1:0] count_reg;
  logic wrap_reg;
  wire logic step = inc && !hold;

  assign count = count_reg;
  assign at_max = &count_reg;
  assign wrap_pulse = wrap_reg;

  // Clear keeps an event that lands in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_reg <= '0;
      wrap_reg <= 1'b0;
    end else begin
      if (clear) begin
        count_reg <= step ? W'(1) : '0;
      end else if (step) begin
        count_reg <= count_reg + W'(1);
      end
      wrap_reg <= step && at_max && !clear;
    end
  end

endmodule : pbr_sat_counter

// ---- logic/pbr_led_ctrl.sv ----
// LED pulse stretching, blinking, mode selection and polarity
module pbr_led_ctrl
  import pbr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tick_ms,
  // Configuration and raw indications
  input wire pbr_led_cfg_t cfg,
  input wire pbr_led_in_t led_in,
  // Pin levels
  output pbr_led_in_t led_out
);

  logic [9:0] stretch_reg;
  logic [9:0] blink_cnt_reg;
  logic blink_phase_reg;
  pbr_led_in_t led_out_reg;
  wire logic act_on = stretch_reg != '0;
  wire logic blink_wrap = blink_cnt_reg >= pbr_code_ms(cfg.blink_rate) - 10'h001;
  wire logic act_blink = act_on && blink_phase_reg;
  wire logic link_on = (cfg.mode == LED_MODE2) ? (cfg.en && led_in.link && !act_blink)
                                               : led_in.link;
  wire logic act_shown = (cfg.mode == LED_MODE3) ? act_on : act_blink;
  // enable gates every LED to its idle level
  wire logic [2:0] on_vec = cfg.en ? {act_shown, led_in.speed, link_on} : 3'h0;
  wire logic [2:0] lvl_vec = ~(on_vec ^ cfg.pol);

  assign led_out = led_out_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stretch_reg <= '0;
      blink_cnt_reg <= '0;
      blink_phase_reg <= 1'b0;
      led_out_reg <= '0;
    end else begin
      // stretch activity to the programmed width
      if (led_in.act) begin
        stretch_reg <= pbr_code_ms(cfg.pulse_width);
      end else if (tick_ms && act_on) begin
        stretch_reg <= stretch_reg - 10'h001;
      end
      if (tick_ms) begin
        blink_cnt_reg <= blink_wrap ? '0 : blink_cnt_reg + 10'h001;
        blink_phase_reg <= blink_wrap ? !blink_phase_reg : blink_phase_reg;
      end
      led_out_reg <= lvl_vec;
    end
  end

endmodule : pbr_led_ctrl

// ---- logic/pbr_regs.sv ----
// Self-test status and counters, LED control, soft reset and false carrier registers
module pbr_regs
  import pbr_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Management register access
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // PRBS checker and generator
  input wire pbr_chk_t chk,
  input wire logic gen_busy,
  input wire logic gen_enable,
  input wire logic prbs_count_mode,
  output logic gen_run,
  output logic prbs_count_wrap,
  output logic [DATA_W-1:0] pkt_len,
  output logic [DATA_W-1:0] pkt_gap,
  // Power and receive indications
  input wire logic core_normal_power,
  input wire logic bad_start_delimiter,
  // LED and interrupt
  input wire pbr_led_in_t led_in,
  input wire logic int_normal,
  input wire logic [1:0] led_mode_strap,
  input wire logic [2:0] led_pol_strap,
  output pbr_led_in_t led_out,
  output logic int_out,
  // Reset of the rest of the PHY
  output logic phy_soft_reset
);

  // ==========================================================
  // Soft reset
  logic soft_rst_reg;
  wire logic rst_all_n = rst_n && !soft_rst_reg;

  // ==========================================================
  // Access decode
  wire logic hit_status = reg_addr == ADDR_SELFTEST_STATUS;
  wire logic hit_led = reg_addr == ADDR_LED_DIRECT_CONTROL;
  wire logic hit_soft = reg_addr == ADDR_SOFT_RESET_CONTROL;
  wire logic hit_fc = reg_addr == ADDR_FALSE_CARRIER_COUNTER;
  wire logic hit_bytes = reg_addr == ADDR_SELFTEST_BYTE_COUNT;
  wire logic hit_errs = reg_addr == ADDR_SELFTEST_ERROR_COUNT;
  wire logic hit_len = reg_addr == ADDR_SELFTEST_PACKET_LENGTH;
  wire logic hit_gap = reg_addr == ADDR_SELFTEST_PACKET_GAP;
  wire logic wr_led = reg_wr && hit_led;
  wire logic wr_soft = reg_wr && hit_soft;
  wire logic wr_errs = reg_wr && hit_errs;
  wire logic wr_len = reg_wr && hit_len;
  wire logic wr_gap = reg_wr && hit_gap;
  wire logic rd_status = reg_rd && hit_status;
  wire logic rd_fc = reg_rd && hit_fc;

  wire logic lock_req = wr_errs && (reg_wdata[LOCK_BIT] || reg_wdata[LOCK_CLR_BIT]);
  wire logic clear_req = wr_errs && reg_wdata[LOCK_CLR_BIT];

  // bit 15 write starts a whole-PHY reset pulse
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_soft && reg_wdata[SOFT_RESET_BIT];
    end
  end

  // ==========================================================
  // Strap inputs
  logic [4:0] strap_s1;
  logic [4:0] strap_s2;
  logic [4:0] strap_s3;
  logic [4:0] strap_held_reg;

  always_ff @(posedge clock) begin
    strap_s1 <= {led_mode_strap, led_pol_strap};
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
  end

  // Strap value counts once two stages agree
  always_ff @(posedge clock) begin
    if (strap_s2 == strap_s3) begin
      strap_held_reg <= strap_s3;
    end
  end

  // ==========================================================
  // Millisecond tick for the LED timers
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick_reg;
  wire logic tick_wrap = tick_cnt_reg == TICK_LAST;

  always_ff @(posedge clock) begin
    if (!rst_all_n) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_wrap ? '0 : tick_cnt_reg + TICK_W'(1);
      tick_reg <= tick_wrap;
    end
  end

  // ==========================================================
  // PRBS counters
  logic [BYTE_CNT_W-1:0] byte_live;
  logic [ERR_CNT_W-1:0] err_live;
  logic byte_max;
  logic err_max;
  logic byte_wrap;
  logic err_wrap;
  logic [BYTE_CNT_W-1:0] byte_vis_reg;
  logic [ERR_CNT_W-1:0] err_vis_reg;
  logic wrap_out_reg;

  // single mode halts both counters at either maximum
  wire logic count_hold = !prbs_count_mode && (byte_max || err_max);

  // bytes taken in by the checker
  pbr_sat_counter #(
    .W(BYTE_CNT_W)
  ) u_byte_cnt (
    .clock(clock),
    .rst_n(rst_all_n),
    .clear(clear_req),
    .inc(chk.byte_valid),
    .hold(count_hold),
    .count(byte_live),
    .at_max(byte_max),
    .wrap_pulse(byte_wrap)
  );

  pbr_sat_counter #(
    .W(ERR_CNT_W)
  ) u_err_cnt (
    .clock(clock),
    .rst_n(rst_all_n),
    .clear(clear_req),
    .inc(chk.byte_valid && chk.byte_err),
    .hold(count_hold),
    .count(err_live),
    .at_max(err_max),
    .wrap_pulse(err_wrap)
  );

  // visible values change only on a lock write
  always_ff @(posedge clock) begin
    if (!rst_all_n) begin
      byte_vis_reg <= '0;
      err_vis_reg <= '0;
      wrap_out_reg <= 1'b0;
    end else begin
      if (lock_req) begin
        byte_vis_reg <= byte_live;
        err_vis_reg <= err_live;
      end
      wrap_out_reg <= byte_wrap || err_wrap;
    end
  end

  // ==========================================================
  // Status register
  logic sync_loss_reg;

  // latched high, read clears unless loss persists
  always_ff @(posedge clock) begin
    if (!rst_all_n) begin
      sync_loss_reg <= 1'b0;
    end else if (chk.sync_loss) begin
      sync_loss_reg <= 1'b1;
    end else if (rd_status) begin
      sync_loss_reg <= 1'b0;
    end
  end

  wire logic [DATA_W-1:0] status_word = (DATA_W'(chk.locked) << STAT_LOCKED_BIT)
                                      | (DATA_W'(sync_loss_reg) << STAT_SYNC_LOSS_BIT)
                                      | (DATA_W'(gen_busy) << STAT_GEN_BUSY_BIT)
                                      | (DATA_W'(core_normal_power) << STAT_POWER_BIT);

  // ==========================================================
  // False carrier counter
  logic [FC_CNT_W-1:0] fc_cnt_reg;
  wire logic fc_full = &fc_cnt_reg;

  // count error nibbles, read clears, event beats clear
  always_ff @(posedge clock) begin
    if (!rst_all_n) begin
      fc_cnt_reg <= '0;
    end else if (rd_fc) begin
      fc_cnt_reg <= bad_start_delimiter ? FC_CNT_W'(1) : '0;
    end else if (bad_start_delimiter && !fc_full) begin
      fc_cnt_reg <= fc_cnt_reg + FC_CNT_W'(1);
    end
  end

  // ==========================================================
  // Packet length and gap
  logic [DATA_W-1:0] pkt_len_reg;
  logic [DATA_W-1:0] pkt_gap_reg;

  always_ff @(posedge clock) begin
    if (!rst_all_n) begin
      pkt_len_reg <= PKT_LEN_RST;
      pkt_gap_reg <= PKT_GAP_RST;
    end else begin
      if (wr_len) begin
        pkt_len_reg <= reg_wdata;
      end
      if (wr_gap) begin
        pkt_gap_reg <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // LED direct control
  pbr_led_cfg_t led_cfg_reg;
  logic force_int_reg;

  always_ff @(posedge clock) begin
    if (!rst_all_n) begin
      led_cfg_reg.en <= LED_EN_RST;
      led_cfg_reg.pulse_width <= LED_PW_RST;
      led_cfg_reg.blink_rate <= LED_BLINK_RST;
      led_cfg_reg.mode <= strap_held_reg[4:3];
      led_cfg_reg.pol <= strap_held_reg[2:0];
      force_int_reg <= LED_FORCE_RST;
    end else if (wr_led) begin
      led_cfg_reg.en <= reg_wdata[LED_EN_BIT];
      led_cfg_reg.pulse_width <= reg_wdata[LED_PW_LSB +: 2];
      led_cfg_reg.blink_rate <= reg_wdata[LED_BLINK_LSB +: 2];
      led_cfg_reg.mode <= reg_wdata[LED_MODE_LSB +: 2];
      led_cfg_reg.pol <= reg_wdata[LED_POL_LSB +: 3];
      force_int_reg <= reg_wdata[LED_FORCE_INT_BIT];
    end
  end

  wire logic [DATA_W-1:0] led_word = (DATA_W'(led_cfg_reg.en) << LED_EN_BIT)
                                   | (DATA_W'(led_cfg_reg.pulse_width) << LED_PW_LSB)
                                   | (DATA_W'(force_int_reg) << LED_FORCE_INT_BIT)
                                   | (DATA_W'(led_cfg_reg.blink_rate) << LED_BLINK_LSB)
                                   | (DATA_W'(led_cfg_reg.mode) << LED_MODE_LSB)
                                   | (DATA_W'(led_cfg_reg.pol) << LED_POL_LSB);

  pbr_led_ctrl u_led (
    .clock(clock),
    .rst_n(rst_all_n),
    .tick_ms(tick_reg),
    .cfg(led_cfg_reg),
    .led_in(led_in),
    .led_out(led_out)
  );

  // ==========================================================
  // Read path
  // reserved bits and unmapped offsets read zero
  wire logic [DATA_W-1:0] rd_mux =
      hit_status ? status_word :
      hit_led ? led_word :
      hit_soft ? (DATA_W'(soft_rst_reg) << SOFT_RESET_BIT) :
      hit_fc ? DATA_W'(fc_cnt_reg) :
      hit_bytes ? byte_vis_reg :
      hit_errs ? DATA_W'(err_vis_reg) :
      hit_len ? pkt_len_reg :
      hit_gap ? pkt_gap_reg : '0;

  logic [DATA_W-1:0] rdata_reg;
  logic rvalid_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd;
      if (reg_rd) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  // ==========================================================
  // Side outputs
  logic gen_run_reg;
  logic int_reg;

  always_ff @(posedge clock) begin
    if (!rst_all_n) begin
      gen_run_reg <= 1'b0;
      int_reg <= 1'b0;
    end else begin
      gen_run_reg <= gen_enable;
      int_reg <= force_int_reg || int_normal;
    end
  end

  assign gen_run = gen_run_reg;
  assign int_out = int_reg;
  assign prbs_count_wrap = wrap_out_reg;
  assign pkt_len = pkt_len_reg;
  assign pkt_gap = pkt_gap_reg;
  assign phy_soft_reset = soft_rst_reg;

endmodule : pbr_regs

// ---- testbench/pbr_regs_props.sv ----
// Concurrent checks on the ports of the self-test, LED and misc register group
module pbr_regs_props
  import pbr_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register access
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Indications and outputs
  input wire pbr_chk_t chk,
  input wire logic bad_start_delimiter,
  input wire logic int_normal,
  input wire logic [DATA_W-1:0] pkt_len,
  input wire logic [DATA_W-1:0] pkt_gap,
  input wire pbr_led_in_t led_out,
  input wire logic int_out,
  input wire logic phy_soft_reset
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Decodes
  logic [DATA_W-1:0] led_wr_q;
  wire logic rd_stat = reg_rd && reg_addr == ADDR_SELFTEST_STATUS;
  wire logic rd_fc = reg_rd && reg_addr == ADDR_FALSE_CARRIER_COUNTER;
  wire logic rd_err = reg_rd && reg_addr == ADDR_SELFTEST_ERROR_COUNT;
  wire logic wr_led = reg_wr && reg_addr == ADDR_LED_DIRECT_CONTROL;
  wire logic wr_soft = reg_wr && reg_addr == ADDR_SOFT_RESET_CONTROL && reg_wdata[SOFT_RESET_BIT];
  wire logic wr_len = reg_wr && reg_addr == ADDR_SELFTEST_PACKET_LENGTH;

  // Last word written to LED control
  always_ff @(posedge clock) begin
    if (wr_led) begin
      led_wr_q <= reg_wdata;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_STAT_RSVD: assert property (rd_stat |=> reg_rdata[15:12] == 4'h0 && reg_rdata[7:0] == 8'h00)
    else $error("status reserved bits not zero");
  AST_SYNC_LATCH: assert property (chk.sync_loss ##1 !rd_stat ##1 rd_stat |=> reg_rdata[10])
    else $error("sync loss not latched");
  AST_ERR_UPPER: assert property (rd_err |=> reg_rdata[15:8] == 8'h00)
    else $error("error count upper byte not zero");
  AST_FC_CLEAR: assert property ((rd_fc && !bad_start_delimiter) ##1 !bad_start_delimiter ##1 rd_fc
    |=> reg_rdata == 16'h0000)
    else $error("false carrier count not cleared by read");
  AST_INT_NORMAL: assert property (int_normal |=> int_out)
    else $error("normal interrupt not passed");
  AST_INT_FORCE: assert property (wr_led && reg_wdata[LED_FORCE_INT_BIT] ##1 !reg_wr |=> int_out)
    else $error("forced interrupt missing");
  AST_SOFT_PULSE: assert property (wr_soft |=> phy_soft_reset ##1 !phy_soft_reset)
    else $error("soft reset pulse wrong");
  AST_SOFT_REGS: assert property (wr_soft |-> ##3 pkt_len == PKT_LEN_RST && pkt_gap == PKT_GAP_RST)
    else $error("registers not reset by soft reset");
  AST_PKT_LEN: assert property (wr_len |=> pkt_len == $past(reg_wdata))
    else $error("packet length not written");
  AST_LED_OFF: assert property (wr_led && !reg_wdata[LED_EN_BIT] ##1 !wr_led [*3]
    |-> led_out == ~led_wr_q[2:0])
    else $error("disabled LEDs not at off level");

  COV_FC_CLEAR: cover property (rd_fc ##2 rd_fc);
  COV_SOFT: cover property (phy_soft_reset);
  COV_FORCE: cover property (int_out && !int_normal);
endmodule : pbr_regs_props

bind pbr_regs pbr_regs_props #(.TICK_CYCLES(TICK_CYCLES)) pbr_regs_props_i (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .chk(chk),
  .bad_start_delimiter(bad_start_delimiter), .int_normal(int_normal), .pkt_len(pkt_len),
  .pkt_gap(pkt_gap), .led_out(led_out), .int_out(int_out), .phy_soft_reset(phy_soft_reset)
);

// ---- testbench/pbr_mgmt_model.sv ----
// Management controller model that issues strobe reads and writes
module pbr_mgmt_model
  import pbr_pkg::*;
(
  // Clock
  input wire logic clock,
  // Requests
  output logic [ADDR_W-1:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [DATA_W-1:0] reg_wdata,
  // Answers
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end

  // Released lines show the inverse, never a stale value
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    v = reg_rvalid;
  endtask : rd
endmodule : pbr_mgmt_model

// ---- testbench/tb.sv ----
// Self-checking testbench of the self-test, LED and misc register group
module tb
  import pbr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end

  localparam int TICKS = 4;
  localparam logic [7:0] A_ERR = ADDR_SELFTEST_ERROR_COUNT;
  localparam logic [7:0] A_BYTE = ADDR_SELFTEST_BYTE_COUNT;
  localparam logic [7:0] A_LED = ADDR_LED_DIRECT_CONTROL;
  localparam logic [7:0] A_LEN = ADDR_SELFTEST_PACKET_LENGTH;
  localparam logic [7:0] A_STAT = ADDR_SELFTEST_STATUS;
  logic clock, rst_n, reg_wr, reg_rd, reg_rvalid, rvalid, gen_busy, gen_enable, gen_run;
  logic prbs_count_mode, prbs_count_wrap, core_normal_power, bad_start_delimiter;
  logic int_normal, int_out, phy_soft_reset, wrap_seen, sr_seen;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, pkt_len, pkt_gap, rdata, v;
  logic [1:0] led_mode_strap;
  logic [2:0] led_pol_strap;
  pbr_chk_t chk;
  pbr_led_in_t led_in, led_out;
  int n_errors = 0;
  int samples_checked = 0;

  pbr_regs #(.TICK_CYCLES(TICKS)) pbr_regs_i (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .chk(chk),
    .gen_busy(gen_busy), .gen_enable(gen_enable), .prbs_count_mode(prbs_count_mode),
    .gen_run(gen_run), .prbs_count_wrap(prbs_count_wrap), .pkt_len(pkt_len), .pkt_gap(pkt_gap),
    .core_normal_power(core_normal_power), .bad_start_delimiter(bad_start_delimiter),
    .led_in(led_in), .int_normal(int_normal), .led_mode_strap(led_mode_strap),
    .led_pol_strap(led_pol_strap), .led_out(led_out), .int_out(int_out),
    .phy_soft_reset(phy_soft_reset)
  );
  pbr_mgmt_model pbr_mgmt_model_i (
    .clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Sticky event flags, one driver each
  always @(posedge clock) begin
    if (rst_n !== 1'b1) begin
      wrap_seen <= 1'b0;
      sr_seen <= 1'b0;
    end else begin
      if (prbs_count_wrap === 1'b1) wrap_seen <= 1'b1;
      if (phy_soft_reset === 1'b1) sr_seen <= 1'b1;
    end
  end

  // ==========================================================
  // Access and closing tasks
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    pbr_mgmt_model_i.wr(a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    pbr_mgmt_model_i.rd(a, rdata, rvalid);
    `CHK(rvalid, 1'b1);
    `CHK(rdata, e);
  endtask : rdc

  task automatic feed(input int n, input logic e);
    @(negedge clock);
    chk.byte_valid = 1'b1;
    chk.byte_err = e;
    repeat (n) @(negedge clock);
    chk.byte_valid = 1'b0;
  endtask : feed

  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (80000) @(posedge clock);
    n_errors++;
    final_report;
  end

  // ==========================================================
  // Test sequence
  initial begin
    rst_n = 1'b0;
    chk = '0;
    led_in = '0;
    {gen_busy, gen_enable, prbs_count_mode, core_normal_power} = 4'h0;
    {bad_start_delimiter, int_normal} = 2'h0;
    led_mode_strap = 2'h1;
    led_pol_strap = 3'h5;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    rdc(A_LEN, 16'h05DC);
    rdc(ADDR_SELFTEST_PACKET_GAP, 16'h007D);
    rdc(A_LED, 16'hC225);
    rdc(ADDR_SOFT_RESET_CONTROL, 16'h0000);
    rdc(8'h00, 16'h0000);
    wr(A_LEN, 16'hFFFF);
    rdc(A_LEN, 16'hFFFF);
    `CHK(pkt_len, 16'hFFFF);
    wr(ADDR_SELFTEST_PACKET_GAP, 16'h0000);
    rdc(ADDR_SELFTEST_PACKET_GAP, 16'h0000);
    `CHK(pkt_gap, 16'h0000);
    wr(A_STAT, 16'hFFFF);
    rdc(A_STAT, 16'h0000);
    wr(A_LED, 16'hFFDF);
    rdc(A_LED, 16'hF347);
    `CHK(int_out, 1'b1);
    for (int i = 0; i < 4; i++) begin
      v = {1'b1, i[1:0], 3'h0, i[1:0], 1'b0, 2'(i % 3), 5'h00};
      wr(A_LED, v);
      rdc(A_LED, v);
    end
    wr(A_LED, 16'h0000);
    repeat (4) @(negedge clock);
    `CHK(led_out, 3'h7);
    `CHK(int_out, 1'b0);
    int_normal = 1'b1;
    repeat (2) @(negedge clock);
    `CHK(int_out, 1'b1);
    int_normal = 1'b0;
    // Activity stretched by the shortest pulse width
    wr(A_LED, 16'h8047);
    led_in.act = 1'b1;
    @(negedge clock);
    led_in.act = 1'b0;
    repeat (10) @(negedge clock);
    `CHK(led_out.act, 1'b1);
    repeat (50 * TICKS + 20) @(negedge clock);
    `CHK(led_out.act, 1'b0);
    {chk.locked, gen_busy, core_normal_power, gen_enable} = 4'hF;
    repeat (2) @(negedge clock);
    rdc(A_STAT, 16'h0B00);
    `CHK(gen_run, 1'b1);
    chk.sync_loss = 1'b1;
    @(negedge clock);
    chk.sync_loss = 1'b0;
    rdc(A_STAT, 16'h0F00);
    rdc(A_STAT, 16'h0B00);
    {chk.locked, gen_busy, core_normal_power, gen_enable} = 4'h0;
    repeat (2) @(negedge clock);
    rdc(A_STAT, 16'h0000);
    `CHK(gen_run, 1'b0);
    feed(5, 1'b0);
    feed(3, 1'b1);
    rdc(A_BYTE, 16'h0000);
    wr(A_ERR, 16'h0001);
    rdc(A_BYTE, 16'h0008);
    rdc(A_ERR, 16'h0003);
    feed(2, 1'b0);
    rdc(A_BYTE, 16'h0008);
    wr(A_ERR, 16'h0002);
    rdc(A_BYTE, 16'h000A);
    wr(A_ERR, 16'h0001);
    rdc(A_BYTE, 16'h0000);
    feed(300, 1'b1);
    wr(A_ERR, 16'h0001);
    rdc(A_ERR, 16'h00FF);
    rdc(A_BYTE, 16'h00FF);
    wr(A_ERR, 16'h0002);
    feed(65540, 1'b0);
    wr(A_ERR, 16'h0001);
    rdc(A_BYTE, 16'hFFFF);
    wr(A_ERR, 16'h0002);
    prbs_count_mode = 1'b1;
    feed(258, 1'b1);
    repeat (2) @(negedge clock);
    `CHK(wrap_seen, 1'b1);
    prbs_count_mode = 1'b0;
    repeat (3) begin
      @(negedge clock);
      bad_start_delimiter = 1'b1;
      @(negedge clock);
      bad_start_delimiter = 1'b0;
    end
    rdc(ADDR_FALSE_CARRIER_COUNTER, 16'h0003);
    rdc(ADDR_FALSE_CARRIER_COUNTER, 16'h0000);
    wr(A_LEN, 16'h1234);
    wr(ADDR_SOFT_RESET_CONTROL, 16'h8000);
    repeat (4) @(negedge clock);
    `CHK(sr_seen, 1'b1);
    rdc(A_LEN, 16'h05DC);
    rdc(ADDR_SOFT_RESET_CONTROL, 16'h0000);
    rdc(A_LED, 16'hC225);
    final_report;
  end
endmodule : tb
